// ### rtl/ttx_path.sv
// Transmit path: FIFO, byte serializing, 8B/10B and disparity control
//
// How it works
// R1 - Running disparity starts negative after reset
// R2 - Per-byte force sets disparity to chosen value
// R3 - Current running disparity always on output
// R4 - Mode and value bits steer each byte
// R5 - Invert request emits opposite-disparity character
// R6 - Fabric clock locked to reference clock
// R7 - Transmit FIFO holds exactly four words
// R8 - Overflow and underflow reported on outputs
// R9 - Control bit bypasses the FIFO entirely
// R10 - Byte order selectable, MSB or LSB first
// R11 - Control bit bypasses the encoder, raw out
// R12 - Full standard code table, data and control
// R13 - Eight bits plus K give ten bits
// R14 - K flag chooses control versus data encoding
// R15 - Illegal control byte raises error flag
// R16 - Disparity tracks each encoded character
// R17 - Write-full overflow, read-empty underflow flags
`timescale 1ns/1ps
module ttx_path
  import ttx_pkg::*;
#(
  parameter int BYTES = BYTES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_valid,
  input wire logic [BYTES*8-1:0] tx_data,
  input wire logic [BYTES-1:0] tx_char_is_k,
  input wire logic [BYTES-1:0] tx_disparity_force_mode,
  input wire logic [BYTES-1:0] tx_disparity_force_value,
  output logic tx_fifo_overflow,
  output logic tx_fifo_underflow,
  output logic tx_control_code_error,
  output logic tx_running_disparity_out,
  input wire logic ser_ready,
  output logic ser_valid,
  output logic [9:0] ser_char,
  output logic irq
);

  localparam int IW = (BYTES > 1) ? $clog2(BYTES) : 1;
  localparam int EW = BYTES * LANE_W;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Byte lanes of one, two, four or eight only
  if (BYTES != 1 && BYTES != 2 && BYTES != 4 && BYTES != 8) begin : g_bad
    $error("ttx_path: BYTES must be 1, 2, 4 or 8");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [CTRL_W-1:0] ctrl_reg; // Bypass and order controls
  logic fifo_byp;
  logic enc_byp;
  logic lsb_first;
  logic [IRQ_W-1:0] irq_st_reg; // Sticky events
  logic [IRQ_W-1:0] irq_en_reg; // Event mask
  logic [IRQ_W-1:0] irq_ev; // Events this cycle
  logic [IRQ_W-1:0] irq_clr; // Clear strobe from software
  logic rd_reg; // Running disparity, high is positive
  logic stage_valid_reg; // Word being serialized
  logic [EW-1:0] stage_word_reg;
  logic [IW-1:0] idx_reg; // Position within the word
  logic [EW-1:0] entry_in; // Packed fabric word
  logic [EW-1:0] fifo_rd_data;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_wr;
  logic fifo_rd;
  logic fifo_ovf;
  logic [LW-1:0] fifo_level;
  logic take; // Serializer consumes a character
  logic last; // Final byte of the word
  logic stage_free;
  logic load;
  logic byp_ovf;
  logic [IW-1:0] sel;
  logic [LANE_W-1:0] lane;
  logic [7:0] cur_data;
  logic cur_k;
  logic cur_mode;
  logic cur_val;
  logic rd_used; // Disparity the byte is encoded against
  logic [9:0] enc_code;
  logic enc_rd_out;
  logic enc_kerr;
  logic ser_valid_reg;
  logic [9:0] ser_char_reg;
  logic kerr_reg;
  logic unf_reg;
  logic ovf_reg;
  logic aw_held_reg; // Write address waiting for data
  logic [AXI_AW-1:0] awaddr_reg;
  logic w_held_reg; // Write data waiting for address
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_got;
  logic w_got;
  logic do_write;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lo; // Low byte lane enabled
  logic [31:0] rd_mux;
  logic rd_hit;

  assign fifo_byp = ctrl_reg[CTRL_FIFO_BYP_BIT];
  assign enc_byp = ctrl_reg[CTRL_ENC_BYP_BIT];
  assign lsb_first = ctrl_reg[CTRL_LSB_FIRST_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Pack fabric byte lanes with their control bits
  for (genvar i = 0; i < BYTES; i++) begin : g_pack
    assign entry_in[i*LANE_W +: LANE_W] = {tx_disparity_force_value[i],
      tx_disparity_force_mode[i], tx_char_is_k[i], tx_data[i*8 +: 8]};
  end

  // Fabric shares aclk, so the phase allowance is met by design
  ttx_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo ( // R6
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(fifo_wr),
    .wr_data(entry_in),
    .full(fifo_full),
    .rd_en(fifo_rd),
    .rd_data(fifo_rd_data),
    .empty(fifo_empty),
    .level(fifo_level),
    .overflow(fifo_ovf)
  );

  ////////////////////////////////////////////////////////////////////////
  // Flow between fabric, FIFO and the serializing stage
  assign take = ser_ready && stage_valid_reg;
  assign last = take && (idx_reg == IW'(BYTES - 1));
  assign stage_free = !stage_valid_reg || last;
  assign fifo_wr = tx_valid && !fifo_byp;
  assign fifo_rd = stage_free && !fifo_byp && !fifo_empty;
  // Bypass loads the stage straight from the fabric
  assign load = stage_free && (fifo_byp ? tx_valid : !fifo_empty); // R9
  // Without the FIFO a word that finds the stage busy is lost
  assign byp_ovf = tx_valid && fifo_byp && !stage_free; // R17

  // Stage register and byte position
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_valid_reg <= 1'b0;
      stage_word_reg <= '0;
      idx_reg <= '0;
    end else if (load) begin
      stage_valid_reg <= 1'b1;
      stage_word_reg <= fifo_byp ? entry_in : fifo_rd_data; // R9
      idx_reg <= '0;
    end else if (last) begin
      stage_valid_reg <= 1'b0;
    end else if (take) begin
      idx_reg <= idx_reg + 1'b1;
    end
  end

  // Lane selection gives the byte order on the line
  assign sel = lsb_first ? idx_reg : IW'(BYTES - 1) - idx_reg; // R10
  assign lane = stage_word_reg[sel*LANE_W +: LANE_W];
  assign cur_data = lane[7:0];
  assign cur_k = lane[LANE_K_BIT];
  assign cur_mode = lane[LANE_MODE_BIT];
  assign cur_val = lane[LANE_VAL_BIT];

  // Force takes the value; else value high inverts the running one
  assign rd_used = cur_mode ? cur_val : (rd_reg ^ cur_val); // R2 R4 R5

  ttx_enc8b10b u_enc (
    .data(cur_data),
    .is_k(cur_k),
    .rd_in(rd_used),
    .code(enc_code),
    .rd_out(enc_rd_out),
    .kerr(enc_kerr)
  );

  ////////////////////////////////////////////////////////////////////////
  // Running disparity; unchanged while the encoder is bypassed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_reg <= RD_RESET; // R1
    end else if (take && !enc_byp) begin
      rd_reg <= enc_rd_out; // R16
    end
  end

  // Character and per-character flags toward the line and fabric
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_valid_reg <= 1'b0;
      ser_char_reg <= '0;
      kerr_reg <= 1'b0;
    end else begin
      ser_valid_reg <= take;
      if (take) begin
        // Raw mode: K bit first, then value bit, then data
        ser_char_reg <= enc_byp ? {cur_k, cur_val, cur_data}
                                : enc_code; // R11 R13
      end
      kerr_reg <= take && !enc_byp && enc_kerr; // R15
    end
  end

  // Starving serializer counts as a read from an empty FIFO
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unf_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      unf_reg <= ser_ready && !stage_valid_reg; // R8 R17
      ovf_reg <= fifo_ovf || byp_ovf; // R8 R17
    end
  end

  assign ser_valid = ser_valid_reg;
  assign ser_char = ser_char_reg;
  assign tx_control_code_error = kerr_reg;
  assign tx_fifo_underflow = unf_reg;
  assign tx_fifo_overflow = ovf_reg;
  assign tx_running_disparity_out = rd_reg; // R3

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event beats a clear in the same cycle
  assign irq_ev = {enc_kerr && take && !enc_byp,
                   ser_ready && !stage_valid_reg, fifo_ovf || byp_ovf};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_reg <= IRQ_RESET;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
    end
  end
  assign irq = |(irq_st_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side; address and data may come in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign aw_got = aw_held_reg || (s_axi_awvalid && s_axi_awready);
  assign w_got = w_held_reg || (s_axi_wvalid && s_axi_wready);
  assign do_write = aw_got && w_got && !bvalid_reg;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_lo = w_held_reg ? wstrb_reg[0] : s_axi_wstrb[0];
  assign irq_clr = (do_write && wr_lo && wr_addr == REG_IRQ_CLEAR)
                   ? wr_data[IRQ_W-1:0] : '0;

  // Hold whichever half arrived first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Register writes and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      irq_en_reg <= IRQ_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= RESP_OKAY;
      if (wr_addr == REG_CTRL) begin
        if (wr_lo) ctrl_reg <= wr_data[CTRL_W-1:0];
      end else if (wr_addr == REG_IRQ_ENABLE) begin
        if (wr_lo) irq_en_reg <= wr_data[IRQ_W-1:0];
      end else if (wr_addr == REG_IRQ_CLEAR) begin
        bresp_reg <= RESP_OKAY;
      end else if (wr_addr != REG_STATUS && wr_addr != REG_IRQ_STATUS) begin
        bresp_reg <= RESP_SLVERR; // Unmapped
      end
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read decode; clear register reads as zero
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == REG_CTRL) begin
      rd_mux[CTRL_W-1:0] = ctrl_reg;
    end else if (s_axi_araddr == REG_STATUS) begin
      rd_mux[STATUS_RD_BIT] = rd_reg;
      rd_mux[STATUS_BUSY_BIT] = stage_valid_reg;
      rd_mux[STATUS_LEVEL_LSB +: LW] = fifo_level;
    end else if (s_axi_araddr == REG_IRQ_STATUS) begin
      rd_mux[IRQ_W-1:0] = irq_st_reg;
    end else if (s_axi_araddr == REG_IRQ_ENABLE) begin
      rd_mux[IRQ_W-1:0] = irq_en_reg;
    end else if (s_axi_araddr != REG_IRQ_CLEAR) begin
      rd_hit = 1'b0;
    end
  end

  // Read channel, answer one cycle after the address
  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_starve;
    ser_ready && !stage_valid_reg;
  endsequence
  sequence s_unf_flag;
    tx_fifo_underflow && !ser_valid;
  endsequence
  sequence s_norm_take;
    take && !enc_byp && !cur_mode;
  endsequence

  property p_rd_init;
    @(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) == 1'b0) |-> !tx_running_disparity_out;
  endproperty
  a_rd_init: assert property (p_rd_init) // R1
    else $error("disparity not negative after reset");

  property p_rd_track;
    @(posedge aclk) disable iff (!aresetn)
    s_norm_take |=> rd_reg ==
      ($past(rd_used) ^ ($countones(ser_char_reg) != 5));
  endproperty
  a_rd_track: assert property (p_rd_track) // R16
    else $error("disparity does not follow character");

  property p_invert;
    @(posedge aclk) disable iff (!aresetn)
    s_norm_take and (cur_val && !rd_reg) |=>
      $countones(ser_char_reg) <= 5;
  endproperty
  a_invert: assert property (p_invert) // R5
    else $error("inverted byte used running disparity");

  property p_force;
    @(posedge aclk) disable iff (!aresetn)
    take && !enc_byp && cur_mode |=> tx_running_disparity_out ==
      ($past(cur_val) ^ ($countones(ser_char_reg) != 5));
  endproperty
  a_force: assert property (p_force) // R2
    else $error("forced disparity not applied");

  property p_rd_hold;
    @(posedge aclk) disable iff (!aresetn)
    !take |=> $stable(tx_running_disparity_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) // R3
    else $error("disparity output moved without a character");

  property p_kerr;
    @(posedge aclk) disable iff (!aresetn)
    take && !enc_byp && cur_k && !ttx_is_valid_k(cur_data) |=>
      tx_control_code_error && ser_valid;
  endproperty
  a_kerr: assert property (p_kerr) // R15
    else $error("illegal control byte not flagged");

  property p_data_no_kerr;
    @(posedge aclk) disable iff (!aresetn)
    take && !cur_k |=> !tx_control_code_error;
  endproperty
  a_data_no_kerr: assert property (p_data_no_kerr) // R14
    else $error("data byte flagged as control error");

  property p_ovf;
    @(posedge aclk) disable iff (!aresetn)
    tx_valid && !fifo_byp && fifo_full |=> tx_fifo_overflow;
  endproperty
  a_ovf: assert property (p_ovf) // R17
    else $error("write into full fifo not flagged");

  property p_unf;
    @(posedge aclk) disable iff (!aresetn)
    s_starve |=> s_unf_flag;
  endproperty
  a_unf: assert property (p_unf) // R8
    else $error("starved serializer not flagged");

  property p_enc_byp;
    @(posedge aclk) disable iff (!aresetn)
    take && enc_byp |=> ser_char_reg ==
      {$past(cur_k), $past(cur_val), $past(cur_data)};
  endproperty
  a_enc_byp: assert property (p_enc_byp) // R11
    else $error("raw character altered in bypass");

  property p_order;
    @(posedge aclk) disable iff (!aresetn)
    take && enc_byp && idx_reg == '0 |=> ser_char_reg[7:0] ==
      (lsb_first ? $past(stage_word_reg[7:0])
                 : $past(stage_word_reg[EW-LANE_W +: 8]));
  endproperty
  a_order: assert property (p_order) // R10
    else $error("wrong first byte of word");

  property p_fifo_byp;
    @(posedge aclk) disable iff (!aresetn)
    fifo_byp && tx_valid && stage_free |=>
      stage_valid_reg && stage_word_reg == $past(entry_in);
  endproperty
  a_fifo_byp: assert property (p_fifo_byp) // R9
    else $error("bypass did not load stage directly");

endmodule // ttx_path

// ### rtl/ttx_pkg.sv
// Shared constants and helpers for the transmit line-coding path
package ttx_pkg;

  // Datapath shape
  localparam int BYTES_DEF = 2; // Bytes per fabric word
  localparam int FIFO_DEPTH = 4; // Transmit FIFO entries
  localparam int LANE_W = 11; // Per-byte field: val, mode, k, data
  localparam int LANE_K_BIT = 8;
  localparam int LANE_MODE_BIT = 9;
  localparam int LANE_VAL_BIT = 10;

  // Register map, byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h10;

  // Control fields
  localparam int CTRL_W = 3;
  localparam int CTRL_FIFO_BYP_BIT = 0;
  localparam int CTRL_ENC_BYP_BIT = 1;
  localparam int CTRL_LSB_FIRST_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status fields
  localparam int STATUS_RD_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  localparam int STATUS_LEVEL_LSB = 4;

  // Interrupt fields
  localparam int IRQ_W = 3;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_UNF_BIT = 1;
  localparam int IRQ_KERR_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Running disparity: low means negative
  localparam logic RD_RESET = 1'b0;
  localparam logic [4:0] K28_LOW = 5'h1c;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // True for the twelve legal control codes
  function automatic logic ttx_is_valid_k(input logic [7:0] d);
    return (d[4:0] == K28_LOW) || (d == 8'hf7) || (d == 8'hfb) ||
           (d == 8'hfd) || (d == 8'hfe);
  endfunction

endpackage

// ### rtl/ttx_fifo.sv
// Word FIFO between fabric writes and serializer loads
`timescale 1ns/1ps
module ttx_fifo
  import ttx_pkg::*;
#(
  parameter int WIDTH = LANE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic full,
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  output logic empty,
  output logic [$clog2(DEPTH):0] level,
  output logic overflow
);

  localparam int AW = $clog2(DEPTH);

  // Pointer scheme needs a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ttx_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW:0] wr_ptr_reg; // Extra bit tells full from empty
  logic [AW:0] rd_ptr_reg;

  assign level = wr_ptr_reg - rd_ptr_reg;
  assign full = (level == (AW+1)'(DEPTH)); // R7
  assign empty = (level == '0);
  assign rd_data = mem[rd_ptr_reg[AW-1:0]];
  // Write into a full FIFO is dropped and reported
  assign overflow = wr_en && full; // R17

  ////////////////////////////////////////////////////////////////////////
  // Storage writes, no reset needed on data
  always_ff @(posedge aclk) begin
    if (wr_en && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= wr_data;
    end
  end

  // Pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (wr_en && !full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (rd_en && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_depth;
    @(posedge aclk) disable iff (!aresetn)
    (level <= (AW+1)'(DEPTH)) && (full == (level == (AW+1)'(DEPTH)));
  endproperty
  a_depth: assert property (p_depth) // R7
    else $error("fifo level beyond depth");

endmodule // ttx_fifo

// ### rtl/ttx_enc8b10b.sv
// Combinational 8B/10B character encoder
`timescale 1ns/1ps
module ttx_enc8b10b
  import ttx_pkg::*;
(
  input wire logic [7:0] data,
  input wire logic is_k,
  input wire logic rd_in,
  output logic [9:0] code,
  output logic rd_out,
  output logic kerr
);

  // 5b/6b codes for negative disparity, abcdei with a as MSB
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // 3b/4b codes for negative disparity, fghj with f as MSB
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [3:0] ALT7_4B = 4'h7;

  logic [4:0] x; // Low five bits
  logic [2:0] y; // High three bits
  logic k28; // Special six-bit group
  logic [5:0] b6; // Six-bit before polarity choice
  logic [5:0] c6;
  logic rd_mid; // Disparity between sub-blocks
  logic alt7; // Alternate x.7 to avoid run length five
  logic [3:0] b4;
  logic [3:0] c4;

  assign x = data[4:0];
  assign y = data[7:5];
  assign k28 = is_k && (x == K28_LOW);
  assign kerr = is_k && !ttx_is_valid_k(data); // R15

  ////////////////////////////////////////////////////////////////////////
  // Both sub-blocks pick a polarity from the disparity they see
  always_comb begin
    // Data versus control lookup
    b6 = k28 ? K28_6B : T6[x]; // R12 R14
    // Unbalanced groups and x=7 flip under positive disparity
    c6 = (rd_in && (($countones(b6) != 3) || (!k28 && x == 5'd7)))
         ? ~b6 : b6; // R16
    rd_mid = rd_in ^ ($countones(b6) != 3);
    alt7 = is_k ||
           (!rd_mid && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
           (rd_mid && (x == 5'd11 || x == 5'd13 || x == 5'd14));
    b4 = (y == 3'd7 && alt7) ? ALT7_4B : T4[y];
    if ((rd_mid && (($countones(b4) != 2) || y == 3'd3)) ||
        (k28 && !rd_mid && ($countones(b4) == 2) && y != 3'd3)) begin
      c4 = ~b4; // R16
    end else begin
      c4 = b4;
    end
    rd_out = rd_mid ^ ($countones(c4) != 2); // R16
  end

  // Nine inputs give one ten-bit character, a sent first
  assign code = {c6, c4}; // R13

endmodule // ttx_enc8b10b

// ### tb/ttx_ser_model.sv
// Serializer stand-in: asks at random, records characters
`timescale 1ns/1ps
module ttx_ser_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic ser_valid,
  input wire logic [9:0] ser_char,
  output logic ser_ready = 1'h0
);
  logic [9:0] q[$]; // Characters in line order
  // Random stalls so the stage must hold its word
  always @(posedge aclk) begin
    ser_ready <= go && ($urandom % 4 != 0);
    if (ser_valid) begin
      q.push_back(ser_char);
    end
  end
endmodule // ttx_ser_model

// ### tb/test_transceiver_tx_8b10b_path.sv
// Self-checking bench for the transmit line-coding path
`timescale 1ns/1ps
module test_transceiver_tx_8b10b_path;
  import ttx_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic go = 1'h0; // Lets the serializer ask
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tx_valid = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ser_ready, ser_valid, irq;
  logic [15:0] tx_data = 16'h0;
  logic [1:0] tx_char_is_k = 2'h0, tx_disparity_force_mode = 2'h0;
  logic [1:0] tx_disparity_force_value = 2'h0;
  logic tx_fifo_overflow, tx_fifo_underflow, tx_control_code_error;
  logic tx_running_disparity_out;
  logic [9:0] ser_char;
  // Two negative commas, two positive, then a bad control code and a data byte
  logic [9:0] ex[6] = '{10'h0fa, 10'h0fa, 10'h305, 10'h305, 10'h274, 10'h274};
  int fails = 0, samples_checked = 0;

  ttx_path #(.BYTES(2)) ttx_path_inst (.*);
  ttx_ser_model ttx_ser_model_inst (.*);

  initial forever #25 aclk = ~aclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("%0d checks, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One edge of a bounded wait; a hang ends the run
  task tick(input int n);
    @(posedge aclk);
    if (n > 300) begin
      fails++;
      complete_run;
    end
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    tb = 1'h0;
    for (int n = 0; !tb; n++) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      tick(n);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task axr(input logic [7:0] a);
    logic ta, tb;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    tb = 1'h0;
    for (int n = 0; !tb; n++) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      r = s_axi_rdata;
      rsp = s_axi_rresp;
      tick(n);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  task send(input logic [15:0] d, input logic [1:0] k, m, v);
    tx_valid <= 1'h1;
    tx_data <= d;
    tx_char_is_k <= k;
    tx_disparity_force_mode <= m;
    tx_disparity_force_value <= v;
    @(posedge aclk);
  endtask

  // Serializer pulls until c characters have arrived
  task drain(input int c);
    go <= 1'h1;
    for (int n = 0; ttx_ser_model_inst.q.size() < c; n++) tick(n);
    go <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask

  // Raw character of lane b with the encoder skipped
  function automatic logic [9:0] raw(logic [15:0] d, logic [1:0] k, v, int b);
    return {k[b], v[b], d[b*8+:8]};
  endfunction

  initial begin
    logic [15:0] d;
    logic [1:0] k, m, v;
    r = $urandom(80);
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    #1 check(tx_running_disparity_out, 0);
    @(posedge aclk);
    send(16'hbcbc, 2'h3, 2'h0, 2'h1);
    send(16'hbcbc, 2'h3, 2'h1, 2'h1);
    send(16'h0000, 2'h2, 2'h0, 2'h0);
    tx_valid <= 1'h0;
    drain(6);
    foreach (ex[i]) check(ttx_ser_model_inst.q[i], ex[i]);
    check(tx_running_disparity_out, 0);
    axw(REG_IRQ_ENABLE, 32'h4);
    #1 check(irq, 1);
    @(posedge aclk);
    axr(REG_IRQ_STATUS);
    check(r & 32'h5, 32'h4);
    axw(REG_IRQ_CLEAR, 32'h7);
    #1 check(irq, 0);
    @(posedge aclk);
    $display("coding test done");
    ttx_ser_model_inst.q.delete();
    repeat (6) send($urandom, 2'h0, 2'h0, 2'h0);
    tx_valid <= 1'h0;
    axr(REG_IRQ_STATUS);
    check(r & 32'h1, 32'h1);
    drain(10);
    check(ttx_ser_model_inst.q.size(), 10);
    axw(REG_IRQ_CLEAR, 32'h7);
    go <= 1'h1;
    repeat (8) @(posedge aclk);
    go <= 1'h0;
    axr(REG_IRQ_STATUS);
    check(r & 32'h3, 32'h2);
    axr(8'h40);
    check(rsp, RESP_SLVERR);
    $display("fifo test done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      k = $urandom;
      m = $urandom;
      v = $urandom;
      axw(REG_CTRL, 3 | (i % 2) * 4);
      axr(REG_CTRL);
      check(r, 3 | (i % 2) * 4);
      ttx_ser_model_inst.q.delete();
      send(d, k, m, v);
      tx_valid <= 1'h0;
      drain(2);
      check(ttx_ser_model_inst.q[0], raw(d, k, v, 1 - i % 2));
      check(ttx_ser_model_inst.q[1], raw(d, k, v, i % 2));
    end
    $display("bypass test done");
    complete_run;
  end
endmodule // test_transceiver_tx_8b10b_path
